// File: rtl/rtcsi_pkg.sv
`default_nettype none

package rtcsi_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_ADJUST   = 4'h7;
	localparam logic [3:0] ADDR_INT_CTRL = 4'hE;
	localparam logic [3:0] ADDR_STATUS   = 4'hF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_WEEKLY_EN_BIT  = 7;
	localparam int CTL_DAILY_EN_BIT   = 6;
	localparam int CTL_PER_SEL_LSB    = 0;
	localparam int STS_THRESH_SEL_BIT = 7;
	localparam int STS_LOW_VOLT_BIT   = 6;
	localparam int STS_OSC_RUN_BIT    = 5;
	localparam int STS_POWER_UP_BIT   = 4;
	localparam int STS_PERIODIC_BIT   = 2;
	localparam int STS_WEEKLY_BIT     = 1;
	localparam int STS_DAILY_BIT      = 0;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] ADJUST_RST   = 8'h00;
	localparam logic [7:0] INT_CTRL_RST = 8'h00;
	localparam logic [7:0] STATUS_RST   = 8'h10;
	localparam logic [7:0] STATUS_KEEP  = 8'h30;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 10_000_000;
	localparam int VMON_WINDOW_US  = 7800;
	localparam int VMON_WINDOW_CYC = VMON_WINDOW_US * (CLK_HZ / 1_000_000);
	localparam int OSC_TIMEOUT_NS  = 122070;
	localparam int OSC_TIMEOUT_CYC = (OSC_TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int OSC_REARM_EDGES = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PER_OFF, PER_LOW, PER_2HZ, PER_1HZ, PER_SEC, PER_MIN, PER_HOUR, PER_MONTH
	} rtcsi_per_t;

	typedef struct packed {
		logic sec_tick;
		logic min_roll;
		logic hour_roll;
		logic month_roll;
		logic weekly_match;
		logic daily_match;
	} rtcsi_events_t;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] stable;
	} rtcsi_sync_st_t;

	typedef struct packed {
		logic        prev;
		logic [10:0] cnt;
		logic        halted;
		logic [3:0]  rearm;
		logic        halt_pulse;
	} rtcsi_osc_st_t;

	typedef struct packed {
		logic [7:0]  adj;
		logic [7:0]  ctl;
		logic [7:0]  sts;
		logic [16:0] win_cnt;
		logic        win_on;
		logic [7:0]  rdata;
	} rtcsi_st_t;

endpackage : rtcsi_pkg

`default_nettype wire

// File: rtl/rtcsi_sync.sv
`default_nettype none

module rtcsi_sync
	import rtcsi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] async_in,
	output logic      [2:0] sync_out
);

	rtcsi_sync_st_t st_ff;
	rtcsi_sync_st_t nxt_st;

	// ----------------------------------------------------------------
	// Three stages, accepted once stages two and three agree
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.s1     = async_in;
		nxt_st.s2     = st_ff.s1;
		nxt_st.s3     = st_ff.s2;
		nxt_st.stable = ((st_ff.s2 ~^ st_ff.s3) & st_ff.s3)
		              | ((st_ff.s2 ^ st_ff.s3) & st_ff.stable);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign sync_out = st_ff.stable;

endmodule : rtcsi_sync

`default_nettype wire

// File: rtl/rtcsi_osc_mon.sv
`default_nettype none

module rtcsi_osc_mon
	import rtcsi_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic osc_level,
	output logic      halt_pulse
);

	localparam logic [10:0] TIMEOUT_LAST = 11'(OSC_TIMEOUT_CYC - 1);
	localparam logic [3:0]  REARM_LAST   = 4'(OSC_REARM_EDGES - 1);

	rtcsi_osc_st_t st_ff;
	rtcsi_osc_st_t nxt_st;
	logic          edge_seen;

	// ----------------------------------------------------------------
	// Halt detection
	// ----------------------------------------------------------------
	// A halt is reported once; several clean edges are needed to rearm,
	// so a chattering oscillator cannot toggle the flag repeatedly.
	always_comb
	begin
		nxt_st            = st_ff;
		edge_seen         = osc_level ^ st_ff.prev;
		nxt_st.prev       = osc_level;
		nxt_st.halt_pulse = 1'b0;
		if (edge_seen)
		begin
			nxt_st.cnt = '0;
			if (st_ff.halted)
			begin
				nxt_st.rearm = st_ff.rearm + 4'h1;
				if (st_ff.rearm == REARM_LAST)
				begin
					nxt_st.halted = 1'b0;
					nxt_st.rearm  = '0;
				end
			end
		end
		else if (!st_ff.halted)
		begin
			// [R23] timeout flags halt
			if (st_ff.cnt == TIMEOUT_LAST)
			begin
				nxt_st.halt_pulse = 1'b1;
				nxt_st.halted     = 1'b1;
				nxt_st.cnt        = '0;
				nxt_st.rearm      = '0;
			end
			else
				nxt_st.cnt = st_ff.cnt + 11'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign halt_pulse = st_ff.halt_pulse;

endmodule : rtcsi_osc_mon

`default_nettype wire

// File: rtl/rtcsi_top.sv
// Summary of operation
// [R01] Power-up from zero clears control and adjust registers.
// [R02] Oscillator stop captured as running flag zero.
// [R03] Power-up, low-voltage high active; running flag low.
// [R04] After power-up: power-up one, low-voltage zero.
// [R05] Flags at D4-D6; clear-only except running flag.
// [R06] Power-up flag holds listed fields at zero.
// [R07] Threshold select picks 2.1 or 1.3 volt.
// [R08] Supply checked in 7.8 ms window per second.
// [R09] Sampling stops while low-voltage flag set.
// [R10] Host clears low-voltage flag after seconds write.
// [R11] Weekly alarm drives B, daily drives A.
// [R12] Periodic select gives pulse or level on A.
// [R13] Daily, weekly, periodic flags at D0-D2.
// [R14] Enables at D7, D6; select at D2-D0.
// [R15] All disabled keeps both interrupt outputs released.
// [R16] Output A low when either source low.
// [R17] Flags readable to identify output A source.
// [R18] Writing zero clears alarm flag; one ignored.
// [R19] Clearing flag keeps enable; alarm refires later.
// [R20] Select codes: off, low, 2Hz, 1Hz, levels.
// [R21] Level output stays low until flag cleared.
// [R22] Flags set on event, held until cleared; the periodic flag follows the pulse in 2Hz, 1Hz modes.
// [R23] Halt detected by edge timeout with filtering.
`default_nettype none

module rtcsi_top
	import rtcsi_pkg::*;
#(
	parameter int VMON_CYCLES = VMON_WINDOW_CYC
)
(
	input  wire logic          REF_CLK,
	input  wire logic          RST_N,
	input  wire logic [3:0]    REG_ADDR,
	input  wire logic          REG_WR,
	input  wire logic          REG_RD,
	input  wire logic [7:0]    REG_WDATA,
	output logic      [7:0]    REG_RDATA,
	input  wire rtcsi_events_t TIME_EVT,
	input  wire logic [1:0]    SUBSEC_PHASE,
	input  wire logic          OSC_32K,
	input  wire logic          VDD_BELOW_HIGH,
	input  wire logic          VDD_BELOW_LOW,
	output logic               VMON_SAMPLE_EN,
	output logic      [7:0]    ADJUST_SETTING,
	output logic               HOUR_FORMAT,
	output logic               CLK_OUT_DISABLE_FIRST,
	output logic               CLK_OUT_DISABLE_SECOND,
	output logic               TEST_MODE,
	output logic               IRQ_OUT_A_O,
	output logic               IRQ_OUT_A_OE_N,
	output logic               IRQ_OUT_B_O,
	output logic               IRQ_OUT_B_OE_N
);

	localparam logic [16:0] WIN_LOAD = 17'(VMON_CYCLES);

	rtcsi_st_t  st_ff;
	rtcsi_st_t  nxt_st;
	logic [2:0] pins_sync;
	logic       osc_halt;
	logic       below_thresh;
	logic       wr_adj;
	logic       wr_ctl;
	logic       wr_sts;
	rtcsi_per_t per_sel;
	logic       level_event;
	logic       pulse_low;
	logic       per_out_low;
	logic       daily_out_low;
	logic       weekly_out_low;

	// ----------------------------------------------------------------
	// Pin input conditioning
	// ----------------------------------------------------------------
	rtcsi_sync u_sync (
		.clk      (REF_CLK),
		.rst_n    (RST_N),
		.async_in ({OSC_32K, VDD_BELOW_HIGH, VDD_BELOW_LOW}),
		.sync_out (pins_sync)
	);

	// [R02] oscillator halt detection
	rtcsi_osc_mon u_osc_mon (
		.clk        (REF_CLK),
		.rst_n      (RST_N),
		.osc_level  (pins_sync[2]),
		.halt_pulse (osc_halt)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign wr_adj = REG_WR && (REG_ADDR == ADDR_ADJUST);
	assign wr_ctl = REG_WR && (REG_ADDR == ADDR_INT_CTRL);
	assign wr_sts = REG_WR && (REG_ADDR == ADDR_STATUS);

	// [R20] select code decode
	assign per_sel = rtcsi_per_t'(st_ff.ctl[CTL_PER_SEL_LSB +: 3]);

	// [R07] threshold select
	assign below_thresh = st_ff.sts[STS_THRESH_SEL_BIT] ? pins_sync[0] : pins_sync[1];

	// ----------------------------------------------------------------
	// Periodic source
	// ----------------------------------------------------------------
	// The phase input counts quarter seconds from the seconds increment,
	// so both pulse rates fall on the increment with half duty.
	always_comb
	begin
		level_event = 1'b0;
		pulse_low   = 1'b0;
		unique case (per_sel)
			PER_OFF:   pulse_low = 1'b0;
			PER_LOW:   pulse_low = 1'b1;
			PER_2HZ:   pulse_low = ~SUBSEC_PHASE[0];
			PER_1HZ:   pulse_low = ~SUBSEC_PHASE[1];
			PER_SEC:   level_event = TIME_EVT.sec_tick;
			PER_MIN:   level_event = TIME_EVT.min_roll;
			PER_HOUR:  level_event = TIME_EVT.hour_roll;
			PER_MONTH: level_event = TIME_EVT.month_roll;
		endcase
	end

	// ----------------------------------------------------------------
	// Register and monitor state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;

		// ------------------------------------------------------------
		// Host writes
		// ------------------------------------------------------------
		// [R01] adjust register writable
		if (wr_adj)
		begin
			nxt_st.adj = REG_WDATA;
		end

		// [R14] enables and select storage
		if (wr_ctl)
		begin
			nxt_st.ctl = REG_WDATA;
		end

		// Plain status bits take the written value.
		if (wr_sts)
		begin
			nxt_st.sts[STS_THRESH_SEL_BIT] = REG_WDATA[STS_THRESH_SEL_BIT];
			nxt_st.sts[3]                  = REG_WDATA[3];
		end

		// [R05] power-up flag clear only
		if (wr_sts && !REG_WDATA[STS_POWER_UP_BIT])
		begin
			nxt_st.sts[STS_POWER_UP_BIT] = 1'b0;
		end

		// [R03] flag active levels
		// The running flag is the only monitor bit written both ways, so
		// software can mark the oscillator good again after a halt.
		// [R05] running flag written both ways
		if (wr_sts)
		begin
			nxt_st.sts[STS_OSC_RUN_BIT] = REG_WDATA[STS_OSC_RUN_BIT];
		end
		// [R02] halt wins over write
		if (osc_halt)
		begin
			nxt_st.sts[STS_OSC_RUN_BIT] = 1'b0;
		end

		// [R18] zero clears, one ignored
		if (wr_sts && !REG_WDATA[STS_DAILY_BIT])
		begin
			nxt_st.sts[STS_DAILY_BIT] = 1'b0;
		end
		if (wr_sts && !REG_WDATA[STS_WEEKLY_BIT])
		begin
			nxt_st.sts[STS_WEEKLY_BIT] = 1'b0;
		end
		// [R21] clear returns output high
		if (wr_sts && !REG_WDATA[STS_PERIODIC_BIT])
		begin
			nxt_st.sts[STS_PERIODIC_BIT] = 1'b0;
		end
		if (wr_sts && !REG_WDATA[STS_LOW_VOLT_BIT])
		begin
			nxt_st.sts[STS_LOW_VOLT_BIT] = 1'b0;
		end

		// ------------------------------------------------------------
		// Event flags
		// ------------------------------------------------------------
		// Sets come after the clears, so an event in the cycle of a clear
		// is never lost.
		// [R22] alarm matches set flags
		// [R19] enable untouched by clear
		if (TIME_EVT.daily_match && st_ff.ctl[CTL_DAILY_EN_BIT])
		begin
			nxt_st.sts[STS_DAILY_BIT] = 1'b1;
		end
		if (TIME_EVT.weekly_match && st_ff.ctl[CTL_WEEKLY_EN_BIT])
		begin
			nxt_st.sts[STS_WEEKLY_BIT] = 1'b1;
		end

		// [R22] level event sets flag
		if (level_event)
		begin
			nxt_st.sts[STS_PERIODIC_BIT] = 1'b1;
		end
		// In pulse mode the flag simply mirrors the output waveform.
		// [R13] flag reflects pulse source
		if ((per_sel == PER_2HZ) || (per_sel == PER_1HZ))
		begin
			nxt_st.sts[STS_PERIODIC_BIT] = pulse_low;
		end

		// ------------------------------------------------------------
		// Supply monitor
		// ------------------------------------------------------------
		// The window is counted in reference cycles; a short count in
		// simulation only shortens it, the once-per-second rhythm stays.
		// [R08] window opens each second
		// [R09] no sampling while flagged
		if (st_ff.win_on)
		begin
			nxt_st.win_cnt = st_ff.win_cnt - 17'h00001;
			if (st_ff.win_cnt == 17'h00001)
			begin
				nxt_st.win_on = 1'b0;
			end
		end
		else if (TIME_EVT.sec_tick && !st_ff.sts[STS_LOW_VOLT_BIT])
		begin
			nxt_st.win_on  = 1'b1;
			nxt_st.win_cnt = WIN_LOAD;
		end
		if (st_ff.sts[STS_LOW_VOLT_BIT])
		begin
			nxt_st.win_on = 1'b0;
		end

		// [R07] drop below threshold flagged
		if (st_ff.win_on && !st_ff.sts[STS_LOW_VOLT_BIT] && below_thresh)
		begin
			nxt_st.sts[STS_LOW_VOLT_BIT] = 1'b1;
		end

		// ------------------------------------------------------------
		// Power-up hold
		// ------------------------------------------------------------
		// [R06] power-up flag forces zeros
		if (st_ff.sts[STS_POWER_UP_BIT])
		begin
			nxt_st.adj = ADJUST_RST;
			nxt_st.ctl = INT_CTRL_RST;
			nxt_st.sts = nxt_st.sts & STATUS_KEEP;
		end

		// ------------------------------------------------------------
		// Read capture
		// ------------------------------------------------------------

		// Read data is captured on the strobe; unmapped offsets read zero.
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				ADDR_ADJUST:   nxt_st.rdata = st_ff.adj;
				ADDR_INT_CTRL: nxt_st.rdata = st_ff.ctl;
				// [R17] flags readable
				ADDR_STATUS:   nxt_st.rdata = st_ff.sts;
				default:       nxt_st.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			// [R01] power-up defaults
			// [R04] power-up one, low-voltage zero
			st_ff.adj     <= ADJUST_RST;
			st_ff.ctl     <= INT_CTRL_RST;
			st_ff.sts     <= STATUS_RST;
			st_ff.win_cnt <= '0;
			st_ff.win_on  <= 1'b0;
			st_ff.rdata   <= 8'h00;
		end
		else
			st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// Interrupt outputs
	// ----------------------------------------------------------------
	// [R11] alarm outputs follow flag
	assign daily_out_low  = st_ff.sts[STS_DAILY_BIT] & st_ff.ctl[CTL_DAILY_EN_BIT];
	assign weekly_out_low = st_ff.sts[STS_WEEKLY_BIT] & st_ff.ctl[CTL_WEEKLY_EN_BIT];

	// [R12] periodic drive on A
	always_comb
	begin
		unique case (per_sel)
			PER_OFF:
				per_out_low = 1'b0;
			PER_LOW, PER_2HZ, PER_1HZ:
				per_out_low = pulse_low;
			PER_SEC, PER_MIN, PER_HOUR, PER_MONTH:
				per_out_low = st_ff.sts[STS_PERIODIC_BIT];
		endcase
	end

	// Both outputs are open drain; they only ever pull low, and the
	// enable is low while the pin is pulled.
	// [R16] either source pulls A
	// [R15] released when disabled
	assign IRQ_OUT_A_O    = 1'b0;
	assign IRQ_OUT_A_OE_N = ~(daily_out_low | per_out_low);
	assign IRQ_OUT_B_O    = 1'b0;
	assign IRQ_OUT_B_OE_N = ~weekly_out_low;

	// ----------------------------------------------------------------
	// Register-driven outputs
	// ----------------------------------------------------------------
	assign REG_RDATA              = st_ff.rdata;
	assign VMON_SAMPLE_EN         = st_ff.win_on;
	assign ADJUST_SETTING         = st_ff.adj;
	assign HOUR_FORMAT            = st_ff.ctl[5];
	assign CLK_OUT_DISABLE_SECOND = st_ff.ctl[4];
	assign TEST_MODE              = st_ff.ctl[3];
	assign CLK_OUT_DISABLE_FIRST  = st_ff.sts[3];

endmodule : rtcsi_top

`default_nettype wire

// File: verification/rtcsi_chk.sv
`default_nettype none

module rtcsi_chk
	import rtcsi_pkg::*;
#(
	parameter int VMON_CYCLES = 20
)
(
	input wire logic          REF_CLK,
	input wire logic          RST_N,
	input wire logic [3:0]    REG_ADDR,
	input wire logic          REG_WR,
	input wire logic          REG_RD,
	input wire logic [7:0]    REG_WDATA,
	input wire logic [7:0]    REG_RDATA,
	input wire rtcsi_events_t TIME_EVT,
	input wire logic [1:0]    SUBSEC_PHASE,
	input wire logic          VMON_SAMPLE_EN,
	input wire logic [7:0]    ADJUST_SETTING,
	input wire logic          TEST_MODE,
	input wire logic          IRQ_OUT_A_OE_N,
	input wire logic          IRQ_OUT_B_OE_N
);
	timeunit 1ns;
	timeprecision 1ns;

	logic        pon_ff;
	logic [7:0]  ctl_ff;
	logic [16:0] win_ff;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ------------------------------------------------
	// Shadow state
	// ------------------------------------------------
	// Shadows rebuilt from the bus and the window output, since the checker cannot see inside.
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pon_ff <= 1'b1;
			ctl_ff <= 8'h00;
			win_ff <= 17'h00000;
		end
		else
		begin
			if (REG_WR && REG_ADDR == ADDR_STATUS && !REG_WDATA[STS_POWER_UP_BIT])
				pon_ff <= 1'b0;
			if (REG_WR && REG_ADDR == ADDR_INT_CTRL)
				ctl_ff <= pon_ff ? 8'h00 : REG_WDATA;
			win_ff <= VMON_SAMPLE_EN ? win_ff + 17'h00001 : 17'h00000;
		end
	end

	sequence s_daily_hit;
		TIME_EVT.daily_match && ctl_ff[CTL_DAILY_EN_BIT];
	endsequence
	sequence s_weekly_hit;
		TIME_EVT.weekly_match && ctl_ff[CTL_WEEKLY_EN_BIT];
	endsequence

	a_rst_out_idle: assert property ($rose(RST_N) |-> IRQ_OUT_A_OE_N && IRQ_OUT_B_OE_N)
		else $error("irq pins not idle after reset");
	a_pon_holds_zero: assert property (pon_ff |-> ADJUST_SETTING == 8'h00 && !TEST_MODE)
		else $error("field not held at zero");
	a_idle_released: assert property (ctl_ff == 8'h00 |-> IRQ_OUT_A_OE_N && IRQ_OUT_B_OE_N)
		else $error("irq pin driven while disabled");
	a_fixed_low: assert property (ctl_ff[2:0] == 3'h1 |-> !IRQ_OUT_A_OE_N)
		else $error("fixed low mode not low");
	a_pulse_wave: assert property (ctl_ff[2:0] inside {3'h2, 3'h3} && !ctl_ff[6]
		|-> IRQ_OUT_A_OE_N == SUBSEC_PHASE[ctl_ff[0]]) else $error("pulse wave wrong");
	a_daily_fire: assert property (s_daily_hit |=> !IRQ_OUT_A_OE_N)
		else $error("daily alarm did not drive A");
	a_weekly_fire: assert property (s_weekly_hit |=> !IRQ_OUT_B_OE_N)
		else $error("weekly alarm did not drive B");
	a_weekly_cause: assert property ($fell(IRQ_OUT_B_OE_N)
		|-> $past(TIME_EVT.weekly_match) || $past(REG_WR)) else $error("B fell without cause");
	a_vmon_cause: assert property ($rose(VMON_SAMPLE_EN) |-> $past(TIME_EVT.sec_tick))
		else $error("window opened without tick");
	a_vmon_len: assert property (VMON_SAMPLE_EN |-> win_ff < VMON_CYCLES)
		else $error("window too long");
	a_rdata_hold: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
		else $error("read data moved without read");
endmodule : rtcsi_chk

bind rtcsi_top rtcsi_chk #(.VMON_CYCLES(VMON_CYCLES)) rtcsi_chk_i (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TIME_EVT(TIME_EVT),
	.SUBSEC_PHASE(SUBSEC_PHASE), .VMON_SAMPLE_EN(VMON_SAMPLE_EN),
	.ADJUST_SETTING(ADJUST_SETTING), .TEST_MODE(TEST_MODE),
	.IRQ_OUT_A_OE_N(IRQ_OUT_A_OE_N), .IRQ_OUT_B_OE_N(IRQ_OUT_B_OE_N)
);

`default_nettype wire

// File: verification/rtcsi_host.sv
`default_nettype none

module rtcsi_host
	import rtcsi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [3:0] addr,
	output logic            wr,
	output logic            rd,
	output logic      [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		addr  = 4'h0;
		wr    = 1'b0;
		rd    = 1'b0;
		wdata = 8'h00;
	end

	// ------------------------------------------------
	// Bus cycles
	// ------------------------------------------------
	// Register writes.
	task automatic write_reg(input logic [3:0] a, input logic [7:0] v);
		@(negedge clk);
		addr  = a;
		wdata = v;
		wr    = 1'b1;
		@(negedge clk);
		wr    = 1'b0;
		wdata = ~v;
	endtask : write_reg

	task automatic read_reg(input logic [3:0] a, output logic [7:0] v);
		@(negedge clk);
		addr = a;
		rd   = 1'b1;
		@(negedge clk);
		rd   = 1'b0;
		@(negedge clk);
		v    = rdata;
	endtask : read_reg
endmodule : rtcsi_host

`default_nettype wire

// File: verification/tb_top.sv
`default_nettype none

module tb_top
	import rtcsi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int VMON = 20;
	logic          clk;
	logic          rst_n;
	logic [3:0]    addr;
	logic          wr;
	logic          rd;
	logic [7:0]    wdata;
	logic [7:0]    rdata;
	rtcsi_events_t evt_v;
	logic [1:0]    phase;
	logic          osc;
	logic          osc_on;
	logic          vhi;
	logic          vlo;
	logic          ven;
	logic          irqa;
	logic          irqb;
	int            n_errors;
	int            cmp_count;

	rtcsi_top #(.VMON_CYCLES(VMON)) rtcsi_top_i (
		.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .TIME_EVT(evt_v), .SUBSEC_PHASE(phase),
		.OSC_32K(osc), .VDD_BELOW_HIGH(vhi), .VDD_BELOW_LOW(vlo), .VMON_SAMPLE_EN(ven),
		.ADJUST_SETTING(), .HOUR_FORMAT(), .CLK_OUT_DISABLE_FIRST(),
		.CLK_OUT_DISABLE_SECOND(), .TEST_MODE(), .IRQ_OUT_A_O(), .IRQ_OUT_A_OE_N(irqa),
		.IRQ_OUT_B_O(), .IRQ_OUT_B_OE_N(irqb)
	);
	rtcsi_host rtcsi_host_i (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
		.wdata(wdata));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always
	begin
		#15000;
		if (osc_on)
			osc = ~osc;
	end

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic pins(input logic [1:0] e);
		chk({6'h00, irqa, irqb}, {6'h00, e});
	endtask : pins

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] v;
		rtcsi_host_i.read_reg(a, v);
		chk(v, e);
	endtask : rchk

	task automatic evt(input logic [5:0] e);
		@(negedge clk);
		evt_v = rtcsi_events_t'(e);
		@(negedge clk);
		evt_v = rtcsi_events_t'(6'h00);
	endtask : evt

	task automatic finish_test;
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	// Whole run needs about 3150 cycles; over six times that means a hang.
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	initial
	begin
		rst_n = 1'b0;
		evt_v = rtcsi_events_t'(6'h00);
		phase = 2'h0;
		osc = 1'b0;
		osc_on = 1'b1;
		vhi = 1'b0;
		vlo = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		rchk(ADDR_STATUS, 8'h10);
		rchk(ADDR_INT_CTRL, 8'h00);
		pins(2'b11);
		rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'hFF);
		rtcsi_host_i.write_reg(ADDR_ADJUST, 8'h7F);
		rchk(ADDR_INT_CTRL, 8'h00);
		rchk(ADDR_ADJUST, 8'h00);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h00);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h50);
		rchk(ADDR_STATUS, 8'h00);
		rtcsi_host_i.write_reg(ADDR_ADJUST, 8'h7F);
		rchk(ADDR_ADJUST, 8'h7F);
		rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'hC0);
		evt(6'h01);
		pins(2'b01);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h07);
		rchk(ADDR_STATUS, 8'h01);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h00);
		pins(2'b11);
		rchk(ADDR_INT_CTRL, 8'hC0);
		evt(6'h02);
		pins(2'b10);
		rchk(ADDR_STATUS, 8'h02);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h00);
		evt(6'h02);
		pins(2'b10);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h00);
		rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'h44);
		evt(6'h20);
		evt(6'h01);
		rchk(ADDR_STATUS, 8'h05);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h01);
		pins(2'b01);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h00);
		pins(2'b11);
		for (int i = 0; i < 4; i++)
		begin
			rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'h04 + 8'(i));
			evt(6'h20 >> ((i + 1) % 4));
			pins(2'b11);
			evt(6'h20 >> i);
			rchk(ADDR_STATUS, 8'h04);
			pins(2'b01);
			rtcsi_host_i.write_reg(ADDR_STATUS, 8'h00);
			pins(2'b11);
		end
		rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'h01);
		pins(2'b01);
		for (int s = 2; s < 4; s++)
		begin
			rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'(s));
			for (int p = 0; p < 4; p++)
			begin
				phase = 2'(p);
				@(negedge clk);
				pins({phase[s - 2], 1'b1});
			end
		end
		rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'h00);
		for (int t = 0; t < 2; t++)
		begin
			rtcsi_host_i.write_reg(ADDR_STATUS, 8'(t << 7));
			vhi = t[0];
			repeat (5) @(negedge clk);
			evt(6'h20);
			chk({7'h00, ven}, 8'h01);
			repeat (VMON + 5) @(negedge clk);
			chk({7'h00, ven}, 8'h00);
			rchk(ADDR_STATUS, 8'(t << 7));
			vhi = 1'b1;
			vlo = 1'b1;
			repeat (5) @(negedge clk);
			evt(6'h20);
			rchk(ADDR_STATUS, 8'(t << 7) | 8'h40);
			evt(6'h20);
			chk({7'h00, ven}, 8'h00);
			vhi = 1'b0;
			vlo = 1'b0;
		end
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h00);
		repeat (1500) @(negedge clk);
		rtcsi_host_i.write_reg(ADDR_STATUS, 8'h20);
		rchk(ADDR_STATUS, 8'h20);
		osc_on = 1'b0;
		repeat (1400) @(negedge clk);
		rchk(ADDR_STATUS, 8'h00);
		rtcsi_host_i.write_reg(ADDR_INT_CTRL, 8'hC4);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rchk(ADDR_INT_CTRL, 8'h00);
		rchk(ADDR_STATUS, 8'h10);
		rchk(ADDR_ADJUST, 8'h00);
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
